// ===== ipw_map.svh
// Constants for the prioritised interrupt controller with wake-up routing.
`ifndef IPW_MAP_SVH
`define IPW_MAP_SVH
`define IPW_NUM_IRQ 24
`define IPW_FIRST_EXC 16
`define IPW_PRIO_W 2
`define IPW_EXC_W 6
`define IPW_EXC_NMI 6'h02
`define IPW_EXC_HARDFAULT 6'h03
`define IPW_EXC_NONE 6'h00
`define IPW_RESERVED_MASK 24'h020000
`define IPW_WAKE_SLEEP_MASK 24'hfdfe7f
`define IPW_WAKE_HIB_MASK 24'h00000b
`define IPW_NMI_SRC_OFF 2'h0
`define IPW_NMI_SRC_PIN 2'h1
`define IPW_NMI_SRC_CLKLOSS 2'h2
`define IPW_NMI_SRC_BROWNOUT 2'h3
`endif

// ===== ipw_pkg.sv
// Types for the prioritised interrupt controller with wake-up routing.
package ipw_pkg;
   typedef enum logic [1:0] {
      IPW_RUN = 2'b00,
      IPW_SLEEP = 2'b01,
      IPW_HIBERNATE = 2'b10,
      IPW_SHUTDOWN = 2'b11
   } ipw_mode_t;
   typedef enum logic [1:0] {
      IPW_WAKE_NONE = 2'b00,
      IPW_WAKE_RESUME = 2'b01,
      IPW_WAKE_RESTART = 2'b10
   } ipw_wake_t;
endpackage

// ===== ipw_controller.sv
// Prioritised interrupt controller with non-maskable steering and wake routing.
`include "ipw_map.svh"
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Takes 24 peripheral lines, numbered from exception 16 upward.
// - Every programmable line has exactly four priority levels.
// - Software sets each line's priority on its own.
// - During a handler only strictly higher priority requests reach the core.
// - Equal priority ties go to the lower exception number.
// - Non-maskable source is off, pin, clock loss or brownout.
// - Reset, non-maskable, hard fault sit above all programmable levels; NMI not in shutdown.
// - Only a fixed subset of lines may wake the core.
// - Lines 16, 17, 19 wake from sleep and hibernate; shutdown only by pin toggle.
// - Converter line 21 wakes from sleep only.
// - Random source line 22 wakes from sleep only.
// - Hard fault never wakes the core.
// - A wake from sleep resumes execution in run mode.
// - A wake from hibernate restarts the core at the reset vector.
module ipw_controller
   import ipw_pkg::*;
#(
   parameter int NUM_IRQ = `IPW_NUM_IRQ
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Peripheral request pins, bit 0 is exception 16.
   input wire logic [NUM_IRQ-1:0] irqPin,
   // Priority and enable configuration from software.
   input wire logic [NUM_IRQ*`IPW_PRIO_W-1:0] irqPrio,
   input wire logic [NUM_IRQ-1:0] irqEnable,
   input wire logic [NUM_IRQ-1:0] pendClear,
   // Non-maskable source selection and source pins.
   input wire logic [1:0] nmiSel,
   input wire logic nmiPin,
   input wire logic clockLoss,
   input wire logic brownout,
   input wire logic hardFault,
   // Power mode and the dedicated shutdown wake pin.
   input wire logic [1:0] powerMode,
   input wire logic shutdown_wake_pin,
   // Core side.
   input wire logic coreAck,
   input wire logic handlerActive,
   input wire logic [`IPW_PRIO_W-1:0] activePrio,
   input wire logic activeFixed,
   output logic irqReq,
   output logic [`IPW_EXC_W-1:0] irqExc,
   output logic [NUM_IRQ-1:0] pendState,
   output logic [1:0] wakeAction
);

   typedef struct packed {
      logic [NUM_IRQ-1:0] pinS1;
      logic [NUM_IRQ-1:0] pinS2;
      logic [NUM_IRQ-1:0] pinLast;
      logic [2:0] nmiS1;
      logic [2:0] nmiS2;
      logic [1:0] wpS1;
      logic [1:0] wpS2;
      logic wpLast;
      logic [NUM_IRQ-1:0] pend;
      logic req;
      logic [`IPW_EXC_W-1:0] exc;
      logic [1:0] wake;
   } ipw_state_t;

   ipw_state_t state_r;
   ipw_state_t state_nxt;

   function automatic logic [`IPW_PRIO_W-1:0] prioOf(input int idx);
      prioOf = irqPrio[idx*`IPW_PRIO_W +: `IPW_PRIO_W];
   endfunction

   logic [NUM_IRQ-1:0] rise;
   logic nmiRaw;
   logic nmiLive;
   logic winFound;
   logic [`IPW_PRIO_W-1:0] winPrio;
   logic [`IPW_EXC_W-1:0] winExc;
   logic [NUM_IRQ-1:0] wakeMask;
   logic wakeHit;
   ipw_mode_t mode;

   always_comb begin
      mode = ipw_mode_t'(powerMode);
      rise = state_r.pinS2 & ~state_r.pinLast;
      // Source is chosen by software; shutdown has no live non-maskable path.
      unique case (nmiSel)
         `IPW_NMI_SRC_PIN: nmiRaw = state_r.nmiS2[0];
         `IPW_NMI_SRC_CLKLOSS: nmiRaw = state_r.nmiS2[1];
         `IPW_NMI_SRC_BROWNOUT: nmiRaw = state_r.nmiS2[2];
         default: nmiRaw = 1'b0;
      endcase
      nmiLive = nmiRaw && mode != IPW_SHUTDOWN;
      // Strict less-than on the level and lowest index first breaks ties.
      winFound = 1'b0;
      winPrio = '0;
      winExc = `IPW_EXC_NONE;
      for (int i = 0; i < NUM_IRQ; i++) begin
         if (state_r.pend[i] && irqEnable[i]) begin
            if (!winFound || prioOf(i) < winPrio) begin
               winFound = 1'b1;
               winPrio = prioOf(i);
               winExc = 6'(i + `IPW_FIRST_EXC);
            end
         end
      end
      // Wake routing per mode; hard fault is not an input here at all.
      unique case (mode)
         IPW_SLEEP: wakeMask = `IPW_WAKE_SLEEP_MASK;
         IPW_HIBERNATE: wakeMask = `IPW_WAKE_HIB_MASK;
         default: wakeMask = '0;
      endcase
      wakeHit = |(state_r.pend & irqEnable & wakeMask)
         || (nmiLive && mode != IPW_RUN)
         || (mode == IPW_SHUTDOWN && state_r.wpS2[1] != state_r.wpLast);
   end

   always_comb begin
      state_nxt = state_r;
      state_nxt.pinS1 = irqPin;
      state_nxt.pinS2 = state_r.pinS1;
      state_nxt.pinLast = state_r.pinS2;
      state_nxt.nmiS1 = {brownout, clockLoss, nmiPin};
      state_nxt.nmiS2 = state_r.nmiS1;
      state_nxt.wpS1 = {state_r.wpS1[0], shutdown_wake_pin};
      state_nxt.wpS2 = {state_r.wpS2[0], state_r.wpS1[1]};
      state_nxt.wpLast = state_r.wpS2[1];
      // Clear first so a same-cycle edge sets the flag again.
      state_nxt.pend = state_r.pend & ~pendClear;
      if (coreAck && state_r.req && state_r.exc >= `IPW_FIRST_EXC) begin
         state_nxt.pend[state_r.exc - `IPW_FIRST_EXC] = 1'b0;
      end
      state_nxt.pend = (state_nxt.pend | rise) & ~`IPW_RESERVED_MASK;
      // Fixed exceptions outrank every programmable level.
      state_nxt.req = 1'b0;
      state_nxt.exc = `IPW_EXC_NONE;
      if (hardFault && !(handlerActive && activeFixed)) begin
         state_nxt.req = 1'b1;
         state_nxt.exc = `IPW_EXC_HARDFAULT;
      end else if (nmiLive && !(handlerActive && activeFixed)) begin
         state_nxt.req = 1'b1;
         state_nxt.exc = `IPW_EXC_NMI;
      end else if (winFound && (!handlerActive || (!activeFixed && winPrio < activePrio))) begin
         state_nxt.req = 1'b1;
         state_nxt.exc = winExc;
      end
      if (mode == IPW_SLEEP && wakeHit) begin
         state_nxt.wake = IPW_WAKE_RESUME;
      end else if (mode != IPW_RUN && mode != IPW_SLEEP && wakeHit) begin
         state_nxt.wake = IPW_WAKE_RESTART;
      end else begin
         state_nxt.wake = IPW_WAKE_NONE;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign irqReq = state_r.req;
   assign irqExc = state_r.exc;
   assign pendState = state_r.pend;
   assign wakeAction = state_r.wake;

   a_reserved_never: assert property (@(posedge clock) disable iff (rst)
      !pendState[17]) else $error("Reserved exception pending.");
   a_preempt_strict: assert property (@(posedge clock) disable iff (rst)
      $past(handlerActive) && !$past(activeFixed) && irqReq && irqExc >= 6'h10
      |-> prioOf(int'(irqExc) - 16) < $past(activePrio)
      || $past(pendClear) != '0) else $error("Preempted without higher level.");
   a_tie_lower: assert property (@(posedge clock) disable iff (rst)
      $past(winFound) && !$past(hardFault) && !$past(nmiLive) && !$past(handlerActive)
      |-> irqExc == $past(winExc)) else $error("Wrong winner granted.");
   a_hf_first: assert property (@(posedge clock) disable iff (rst)
      $past(hardFault) && !$past(handlerActive) |-> irqExc == 6'h03)
      else $error("Hard fault not first.");
   a_nmi_shutdown: assert property (@(posedge clock) disable iff (rst)
      $past(powerMode) == 2'h3 && !$past(hardFault) |-> irqExc != 6'h02)
      else $error("NMI in shutdown.");
   a_pend_holds: assert property (@(posedge clock) disable iff (rst)
      pendState[0] && !pendClear[0] && !(coreAck && irqReq && irqExc == 6'h10)
      |=> pendState[0]) else $error("Pending dropped.");
   a_edge_pends: assert property (@(posedge clock) disable iff (rst)
      rise[0] |=> pendState[0]) else $error("Edge lost.");
   a_run_nowake: assert property (@(posedge clock) disable iff (rst)
      $past(powerMode) == 2'h0 |-> wakeAction == 2'h0) else $error("Wake in run.");
   a_hib_adc: assert property (@(posedge clock) disable iff (rst)
      $past(powerMode) == 2'h2 && $past(wakeAction) == 2'h0 && $past(pendState) == 24'h20
      && !$past(nmiLive) |-> wakeAction == 2'h0) else $error("Converter woke hibernate.");
   a_sleep_resume: assert property (@(posedge clock) disable iff (rst)
      $past(powerMode) == 2'h1 && wakeAction != 2'h0 |-> wakeAction == 2'h1)
      else $error("Sleep wake not resume.");
   a_hib_restart: assert property (@(posedge clock) disable iff (rst)
      $past(powerMode) == 2'h2 && wakeAction != 2'h0 |-> wakeAction == 2'h2)
      else $error("Hibernate wake not restart.");

   // The checks below use literal numbers so a wrong constant in the map still shows up.
   // A request always carries a fixed or a peripheral exception number.
   a_exc_range: assert property (@(posedge clock) disable iff (rst)
      irqReq |-> irqExc == 6'h02 || irqExc == 6'h03 || (irqExc >= 6'h10 && irqExc <= 6'h27))
      else $error("Request number out of range.");

   // The reserved number is never presented to the core.
   a_reserved_req: assert property (@(posedge clock) disable iff (rst)
      irqExc != 6'h21)
      else $error("Reserved number requested.");

   // A software clear without a new edge empties the flag.
   a_pend_clear: assert property (@(posedge clock) disable iff (rst)
      pendClear[0] && !rise[0] |=> !pendState[0])
      else $error("Clear ignored.");

   // An accepted request leaves the pending set unless a new edge arrives.
   a_ack_clears: assert property (@(posedge clock) disable iff (rst)
      coreAck && irqReq && irqExc == 6'h10 && !rise[0] |=> !pendState[0])
      else $error("Accepted request still pending.");

   // Nothing to serve means no request.
   a_no_req_empty: assert property (@(posedge clock) disable iff (rst)
      $past(pendState & irqEnable) == 24'h0 && !$past(hardFault) && !$past(nmiLive) |-> !irqReq)
      else $error("Request with nothing pending.");

   // A fixed-priority handler cannot be preempted by anything.
   a_fixed_blocks: assert property (@(posedge clock) disable iff (rst)
      $past(handlerActive) && $past(activeFixed) |-> !irqReq)
      else $error("Fixed handler preempted.");

   // The non-maskable request outranks every programmable line.
   a_nmi_over_prog: assert property (@(posedge clock) disable iff (rst)
      $past(nmiLive) && !$past(hardFault) && !$past(handlerActive) |-> irqReq && irqExc == 6'h02)
      else $error("NMI not granted first.");

   // Pin, wakeup timer and external lines wake hibernate with a restart.
   a_hib_wake: assert property (@(posedge clock) disable iff (rst)
      $past(powerMode) == 2'h2 && ($past(pendState & irqEnable) & 24'h00000b) != 24'h0
      |-> wakeAction == 2'h2) else $error("Hibernate wake line ignored.");

   // Every sleep-capable line wakes sleep with a resume.
   a_sleep_any: assert property (@(posedge clock) disable iff (rst)
      $past(powerMode) == 2'h1 && ($past(pendState & irqEnable) & 24'hfdfe7f) != 24'h0
      |-> wakeAction == 2'h1) else $error("Sleep wake line ignored.");

   // The random source wakes sleep.
   a_rng_sleep: assert property (@(posedge clock) disable iff (rst)
      $past(powerMode) == 2'h1 && $past(pendState[6] && irqEnable[6]) |-> wakeAction == 2'h1)
      else $error("Random source did not wake sleep.");

   // The converter wakes sleep.
   a_adc_sleep: assert property (@(posedge clock) disable iff (rst)
      $past(powerMode) == 2'h1 && $past(pendState[5] && irqEnable[5]) |-> wakeAction == 2'h1)
      else $error("Converter did not wake sleep.");

   // The random source alone cannot wake hibernate.
   a_rng_hib: assert property (@(posedge clock) disable iff (rst)
      $past(powerMode) == 2'h2 && $past(pendState) == 24'h40 && !$past(nmiLive)
      |-> wakeAction == 2'h0) else $error("Random source woke hibernate.");

   // A hard fault alone never wakes the core.
   a_hf_nowake: assert property (@(posedge clock) disable iff (rst)
      $past(hardFault) && $past(pendState & irqEnable) == 24'h0 && !$past(nmiLive)
      |-> wakeAction == 2'h0) else $error("Hard fault woke the core.");

   // Shutdown only ever restarts.
   a_shutdown_pin: assert property (@(posedge clock) disable iff (rst)
      $past(powerMode) == 2'h3 && wakeAction != 2'h0 |-> wakeAction == 2'h2)
      else $error("Shutdown wake not restart.");

   // With the source switched off no non-maskable request appears.
   a_nmi_steer: assert property (@(posedge clock) disable iff (rst)
      $past(nmiSel) == 2'h0 |-> irqExc != 6'h02)
      else $error("NMI raised while off.");

   // The non-maskable source wakes sleep.
   a_nmi_wakes: assert property (@(posedge clock) disable iff (rst)
      $past(nmiLive) && $past(powerMode) == 2'h1 |-> wakeAction == 2'h1)
      else $error("NMI did not wake sleep.");

   // The non-maskable source wakes hibernate with a restart.
   a_hib_nmi: assert property (@(posedge clock) disable iff (rst)
      $past(nmiLive) && $past(powerMode) == 2'h2 |-> wakeAction == 2'h2)
      else $error("NMI did not wake hibernate.");

   // Lines outside the hibernate subset stay quiet there.
   a_hib_subset: assert property (@(posedge clock) disable iff (rst)
      $past(powerMode) == 2'h2 && !$past(nmiLive) && ($past(pendState) & 24'h00000b) == 24'h0
      |-> wakeAction == 2'h0) else $error("Hibernate woken by other line.");

   // Lines outside the sleep subset stay quiet there.
   a_sleep_subset: assert property (@(posedge clock) disable iff (rst)
      $past(powerMode) == 2'h1 && !$past(nmiLive) && ($past(pendState) & 24'hfdfe7f) == 24'h0
      |-> wakeAction == 2'h0) else $error("Sleep woken by other line.");

   c_grant: cover property (@(posedge clock) disable iff (rst) irqReq && irqExc >= 6'h10);
   c_nmi: cover property (@(posedge clock) disable iff (rst) irqReq && irqExc == 6'h02);
   c_resume: cover property (@(posedge clock) disable iff (rst) wakeAction == 2'h1);
   c_restart: cover property (@(posedge clock) disable iff (rst) wakeAction == 2'h2);
   c_hard: cover property (@(posedge clock) disable iff (rst) irqReq && irqExc == 6'h03);

endmodule

`default_nettype wire

// ===== ipw_core_model.sv
// Behavioural processor core that takes vectored requests after a set delay.
`timescale 1ns/10ps
`default_nettype none
module ipw_core_model (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Request from the controller.
   input wire logic irqReq,
   input wire logic [5:0] irqExc,
   // Acceptance switch and extra wait cycles.
   input wire logic ackOn,
   input wire logic [1:0] ackWait,
   // Acceptance pulse and the number taken.
   output logic coreAck,
   output logic [5:0] takenExc
);
   int cnt;
   // The request lags an acceptance by two edges, so the core waits that out.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         coreAck <= 1'b0;
         takenExc <= 6'h0;
         cnt <= 0;
      end else begin
         coreAck <= 1'b0;
         if (cnt < 0) cnt <= cnt + 1;
         else if (!(irqReq && ackOn)) cnt <= 0;
         else if (cnt < ackWait) cnt <= cnt + 1;
         else begin
            coreAck <= 1'b1;
            takenExc <= irqExc;
            cnt <= -2;
         end
      end
   end
endmodule
`default_nettype wire

// ===== interrupt_priority_wake_tb.sv
// Self-checking bench for the interrupt controller with wake routing.
`timescale 1ns/10ps
`default_nettype none
module interrupt_priority_wake_tb;
   logic clock = 1'b0, rst = 1'b1, nmiPin = 1'b0, clockLoss = 1'b0, brownout = 1'b0;
   logic hardFault = 1'b0, wakePin = 1'b0, ackOn = 1'b0, hAct = 1'b0, hFix = 1'b0;
   logic [23:0] pin = 24'h0, en = 24'hffffff, clr = 24'h0, pend;
   logic [47:0] prio = 48'h0;
   logic [1:0] nmiSel = 2'h0, mode = 2'h0, hPrio = 2'h0, ackWait = 2'h0, wake;
   logic req, ack;
   logic [5:0] exc, taken;
   logic [31:0] seed = 32'h6a3b66ec;
   int error_cnt = 0, tests_run = 0, t, e, p[24], q[$];
   ipw_controller DUT (.clock(clock), .rst(rst), .irqPin(pin), .irqPrio(prio),
      .irqEnable(en), .pendClear(clr), .nmiSel(nmiSel), .nmiPin(nmiPin),
      .clockLoss(clockLoss), .brownout(brownout), .hardFault(hardFault), .powerMode(mode),
      .shutdown_wake_pin(wakePin), .coreAck(ack), .handlerActive(hAct), .activePrio(hPrio),
      .activeFixed(hFix), .irqReq(req), .irqExc(exc), .pendState(pend), .wakeAction(wake));
   ipw_core_model core (.clock(clock), .rst(rst), .irqReq(req), .irqExc(exc),
      .ackOn(ackOn), .ackWait(ackWait), .coreAck(ack), .takenExc(taken));
   always #5 clock = ~clock;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(string n, logic [31:0] x, logic [31:0] s);
      tests_run++;
      if (s !== x) begin
         error_cnt++;
         $display("MISMATCH %s expected %0h seen %0h", n, x, s);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clock);
   endtask
   // Pins are edge sensitive, so each request is a short pulse.
   task automatic fire(logic [23:0] m);
      @(posedge clock);
      pin <= m;
      tick(2);
      pin <= 24'h0;
      tick(4);
   endtask
   task automatic drain();
      clr <= 24'hffffff;
      ackOn <= 1'b1;
      tick(16);
      clr <= 24'h0;
      ackOn <= 1'b0;
   endtask
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      tick(5000);
      error_cnt++;
      test_done();
   end
   initial begin
      tick(2);
      rst <= 1'b0;
      tick(4);
      chk("reset outputs", 0, {req, wake, pend});
      for (int i = 0; i < 24; i++) begin
         p[i] = rnd() % 4;
         prio[2*i +: 2] <= 2'(p[i]);
      end
      for (int l = 0; l < 4; l++) for (int i = 0; i < 24; i++) if (p[i] == l && i != 17) q.push_back(16 + i);
      ackWait <= 2'(rnd());
      ackOn <= 1'b1;
      pin <= 24'hffffff;
      foreach (q[k]) begin
         t = 0;
         do @(negedge clock); while (ack !== 1'b1 && ++t < 40);
         chk("ack seen", 1, ack);
         if (k == 0) chk("pending set", 24'hfdffff, pend);
         chk("served number", q[k], taken);
      end
      @(posedge clock);
      pin <= 24'h0;
      ackOn <= 1'b0;
      $display("priority order test done");
      hAct <= 1'b1;
      hPrio <= 2'h1;
      prio[11:10] <= 2'h1;
      prio[7:6] <= 2'h0;
      fire(24'h20);
      chk("equal level held", 2'h1, {req, pend[5]});
      fire(24'h08);
      chk("higher level", {1'b1, 6'h13}, {req, exc});
      hFix <= 1'b1;
      tick(3);
      chk("fixed handler blocks", 0, req);
      {hAct, hFix} <= 2'h0;
      drain();
      chk("cleared", 0, pend);
      $display("nesting test done");
      mode <= 2'h1;
      hardFault <= 1'b1;
      tick(4);
      chk("fault no wake", 0, wake);
      hardFault <= 1'b0;
      drain();
      for (int m = 1; m < 4; m++) begin
         mode <= 2'(m);
         for (int i = 0; i < 24; i++) begin
            fire(24'h1 << i);
            e = (m == 1) ? ((i != 7 && i != 8 && i != 17) ? 1 : 0) : (m == 2 && i inside {0, 1, 3}) ? 2 : 0;
            chk("wake action", e, wake);
            drain();
         end
      end
      nmiSel <= 2'h3;
      brownout <= 1'b1;
      tick(6);
      chk("shutdown nmi", 0, {req, wake});
      brownout <= 1'b0;
      wakePin <= 1'b1;
      for (t = 0; t < 8 && wake !== 2'h2; t++) tick(1);
      chk("pin toggle wake", 2'h2, wake);
      mode <= 2'h0;
      drain();
      $display("wake test done");
      for (int s = 0; s < 4; s++) begin
         nmiSel <= 2'(s);
         {nmiPin, clockLoss, brownout} <= (s == 0) ? 3'h7 : 3'h4 >> (s - 1);
         fire(24'h1);
         chk("nmi steering", (s == 0) ? 6'h10 : 6'h2, exc);
         hardFault <= (s == 3);
         tick(3);
         if (s == 3) chk("hard fault first", 6'h3, exc);
         {nmiPin, clockLoss, brownout, hardFault} <= 4'h0;
         drain();
      end
      $display("fixed priority test done");
      test_done();
   end
endmodule
`default_nettype wire
